// File: hdl/alrd_pkg.sv
/*
  Constants and types for the axle lock request decoder: the ratio band edges,
  the decoded band codes and the held request codes.
  Assumes the two readings share one converter scale and arrive together.
*/
package alrd_pkg;

  // ratio band edges in hundredths of a percent of the supply reading
  localparam int unsigned RATIO_FULL_SCALE = 10000; // 100.00 percent
  localparam int unsigned OPEN_MAX = 300; // 3.00 percent
  localparam int unsigned REST_MIN = 924; // 9.24 percent
  localparam int unsigned REST_MAX = 1062; // 10.62 percent
  localparam int unsigned FRONT_MIN = 2818; // 28.18 percent
  localparam int unsigned FRONT_MAX = 3166; // 31.66 percent
  localparam int unsigned REAR_MIN = 8519; // 85.19 percent
  localparam int unsigned REAR_MAX = 8989; // 89.89 percent
  localparam int unsigned BATT_MIN = 9700; // 97.00 percent

  // width of the scale factors, enough for RATIO_FULL_SCALE
  localparam int unsigned SCALE_W = 14;

  // decoded band of one sample
  typedef enum logic [2:0] {
    BAND_OPEN = 3'b000,
    BAND_INVALID = 3'b001,
    BAND_REST = 3'b010,
    BAND_FRONT = 3'b011,
    BAND_REAR = 3'b100,
    BAND_BATT = 3'b101
  } alrd_band_t;

  // request held toward the lock control
  typedef enum logic [1:0] {
    REQ_NONE = 2'b00,
    REQ_FRONT = 2'b01,
    REQ_REAR = 2'b10
  } alrd_req_t;

endpackage : alrd_pkg

// File: hdl/alrd_decoder.sv
/*
  Axle lock request decoder: classifies a pair of converter readings (request
  voltage and switch supply voltage) by their ratio and holds the last valid
  front or rear differential lock request.
  Assumes both readings are unsigned codes on one scale, synchronous to clk,
  and qualified by a one-cycle sample_valid strobe.
*/
// Notes on behaviour
// - classify by voltage ratio, not absolute level
// - ratio at most 3.0 percent: open fault
// - 9.24 to 10.62 percent: switch at rest
// - 28.18 to 31.66 percent: front lock request
// - 85.19 to 89.89 percent: rear lock request
// - ratio at least 97.0 percent: battery short
// - non-request bands keep last valid request
`timescale 1ns/1ns

module alrd_decoder #(
  parameter int unsigned ADC_W = 12
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sample_valid,
  input wire logic [ADC_W-1:0] request_voltage,
  input wire logic [ADC_W-1:0] switch_supply_voltage,
  output alrd_pkg::alrd_band_t band_q,
  output logic band_valid_q,
  output alrd_pkg::alrd_req_t held_req_q,
  output logic front_lock_req_q,
  output logic rear_lock_req_q,
  output logic open_fault_q,
  output logic batt_fault_q,
  output logic invalid_q
);

  localparam int unsigned PROD_W = ADC_W + alrd_pkg::SCALE_W;

  // elaboration check on the converter width
  if (ADC_W < 1 || ADC_W > 18) begin : g_bad_width
    $error("alrd_decoder: ADC_W must lie in 1..18");
  end

  ////////////////////////////////////////////////////////////////////////////
  // cross-multiplied ratio compare, no divider needed

  function automatic logic [PROD_W-1:0] scale(input logic [ADC_W-1:0] v, input int unsigned k);
    logic [PROD_W-1:0] kk;
    kk = PROD_W'(k);
    return PROD_W'(v) * kk;
  endfunction : scale

  logic [PROD_W-1:0] req_scaled;
  assign req_scaled = scale(request_voltage, alrd_pkg::RATIO_FULL_SCALE);

  // request percentage against each band edge of the supply reading
  logic le_open;
  logic ge_rest;
  logic le_rest;
  logic ge_front;
  logic le_front;
  logic ge_rear;
  logic le_rear;
  logic ge_batt;
  assign le_open = req_scaled <= scale(switch_supply_voltage, alrd_pkg::OPEN_MAX);
  assign ge_rest = req_scaled >= scale(switch_supply_voltage, alrd_pkg::REST_MIN);
  assign le_rest = req_scaled <= scale(switch_supply_voltage, alrd_pkg::REST_MAX);
  assign ge_front = req_scaled >= scale(switch_supply_voltage, alrd_pkg::FRONT_MIN);
  assign le_front = req_scaled <= scale(switch_supply_voltage, alrd_pkg::FRONT_MAX);
  assign ge_rear = req_scaled >= scale(switch_supply_voltage, alrd_pkg::REAR_MIN);
  assign le_rear = req_scaled <= scale(switch_supply_voltage, alrd_pkg::REAR_MAX);
  assign ge_batt = req_scaled >= scale(switch_supply_voltage, alrd_pkg::BATT_MIN);

  // band selection, faults first so a zero supply still decodes
  alrd_pkg::alrd_band_t band_d;
  always_comb begin
    if (le_open) begin
      band_d = alrd_pkg::BAND_OPEN;
    end else if (ge_batt) begin
      band_d = alrd_pkg::BAND_BATT;
    end else if (ge_rest && le_rest) begin
      band_d = alrd_pkg::BAND_REST;
    end else if (ge_front && le_front) begin
      band_d = alrd_pkg::BAND_FRONT;
    end else if (ge_rear && le_rear) begin
      band_d = alrd_pkg::BAND_REAR;
    end else begin
      band_d = alrd_pkg::BAND_INVALID;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // band and fault flags of the latest sample

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      band_q <= alrd_pkg::BAND_REST;
      open_fault_q <= 1'b0;
      batt_fault_q <= 1'b0;
      invalid_q <= 1'b0;
    end else if (sample_valid) begin
      band_q <= band_d;
      open_fault_q <= (band_d == alrd_pkg::BAND_OPEN);
      batt_fault_q <= (band_d == alrd_pkg::BAND_BATT);
      invalid_q <= (band_d == alrd_pkg::BAND_INVALID);
    end
  end

  // one-cycle strobe marking a fresh band
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      band_valid_q <= 1'b0;
    end else begin
      band_valid_q <= sample_valid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // held request, changed only by a request band

  alrd_pkg::alrd_req_t held_req_d;
  always_comb begin
    held_req_d = held_req_q;
    if (sample_valid && band_d == alrd_pkg::BAND_FRONT) begin
      held_req_d = alrd_pkg::REQ_FRONT;
    end else if (sample_valid && band_d == alrd_pkg::BAND_REAR) begin
      held_req_d = alrd_pkg::REQ_REAR;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      held_req_q <= alrd_pkg::REQ_NONE;
      front_lock_req_q <= 1'b0;
      rear_lock_req_q <= 1'b0;
    end else begin
      held_req_q <= held_req_d;
      front_lock_req_q <= (held_req_d == alrd_pkg::REQ_FRONT);
      rear_lock_req_q <= (held_req_d == alrd_pkg::REQ_REAR);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  // independent percentage of the accepted sample, in hundredths
  logic [PROD_W-1:0] chk_req;
  logic [PROD_W-1:0] chk_sup;
  assign chk_req = PROD_W'(request_voltage) * PROD_W'(alrd_pkg::RATIO_FULL_SCALE);
  assign chk_sup = PROD_W'(switch_supply_voltage);

  a_open_band: assert property (@(posedge clk) disable iff (!rst_n)
    sample_valid && chk_req <= chk_sup * PROD_W'(alrd_pkg::OPEN_MAX)
    |=> band_q == alrd_pkg::BAND_OPEN && open_fault_q && band_valid_q)
    else $error("open band not flagged");

  a_rest_band: assert property (@(posedge clk) disable iff (!rst_n)
    sample_valid && chk_sup != '0 && chk_req >= chk_sup * PROD_W'(alrd_pkg::REST_MIN)
    && chk_req <= chk_sup * PROD_W'(alrd_pkg::REST_MAX)
    |=> band_q == alrd_pkg::BAND_REST && held_req_q == $past(held_req_q))
    else $error("rest band wrong or request changed");

  a_front_band: assert property (@(posedge clk) disable iff (!rst_n)
    sample_valid && chk_req >= chk_sup * PROD_W'(alrd_pkg::FRONT_MIN)
    && chk_req <= chk_sup * PROD_W'(alrd_pkg::FRONT_MAX) && chk_sup != '0
    |=> held_req_q == alrd_pkg::REQ_FRONT && front_lock_req_q && !rear_lock_req_q)
    else $error("front request not taken");

  a_rear_band: assert property (@(posedge clk) disable iff (!rst_n)
    sample_valid && chk_req >= chk_sup * PROD_W'(alrd_pkg::REAR_MIN)
    && chk_req <= chk_sup * PROD_W'(alrd_pkg::REAR_MAX) && chk_sup != '0
    |=> held_req_q == alrd_pkg::REQ_REAR && rear_lock_req_q && !front_lock_req_q)
    else $error("rear request not taken");

  a_batt_band: assert property (@(posedge clk) disable iff (!rst_n)
    sample_valid && chk_req > '0 && chk_req >= chk_sup * PROD_W'(alrd_pkg::BATT_MIN)
    |=> batt_fault_q && !open_fault_q && $stable(held_req_q))
    else $error("battery short not flagged");

  a_gap_invalid: assert property (@(posedge clk) disable iff (!rst_n)
    sample_valid && chk_req > chk_sup * PROD_W'(alrd_pkg::FRONT_MAX)
    && chk_req < chk_sup * PROD_W'(alrd_pkg::REAR_MIN)
    |=> invalid_q && band_q == alrd_pkg::BAND_INVALID)
    else $error("gap not decoded invalid");

  a_hold_request: assert property (@(posedge clk) disable iff (!rst_n)
    band_valid_q && band_q != alrd_pkg::BAND_FRONT && band_q != alrd_pkg::BAND_REAR
    |-> held_req_q == $past(held_req_q))
    else $error("request changed on non-request band");

  a_flags_exclusive: assert property (@(posedge clk) disable iff (!rst_n)
    !(front_lock_req_q && rear_lock_req_q) && (front_lock_req_q == (held_req_q == alrd_pkg::REQ_FRONT)))
    else $error("request outputs disagree");

  a_reset_none: assert property (@(posedge clk)
    $rose(rst_n) |-> held_req_q == alrd_pkg::REQ_NONE && !front_lock_req_q && !rear_lock_req_q)
    else $error("request not cleared by reset");

  // the three other gaps, below the front band and above the rear band
  a_other_gaps: assert property (@(posedge clk) disable iff (!rst_n)
    sample_valid
    && ((chk_req > chk_sup * PROD_W'(alrd_pkg::OPEN_MAX) && chk_req < chk_sup * PROD_W'(alrd_pkg::REST_MIN))
    || (chk_req > chk_sup * PROD_W'(alrd_pkg::REST_MAX) && chk_req < chk_sup * PROD_W'(alrd_pkg::FRONT_MIN))
    || (chk_req > chk_sup * PROD_W'(alrd_pkg::REAR_MAX) && chk_req < chk_sup * PROD_W'(alrd_pkg::BATT_MIN)))
    |=> invalid_q && band_q == alrd_pkg::BAND_INVALID && !open_fault_q && !batt_fault_q)
    else $error("outer gap not decoded invalid");

  // band, held request and fault flags hold, strobe low, between accepted samples
  a_idle_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !sample_valid
    |=> !band_valid_q && $stable(band_q) && $stable(held_req_q) && $stable(open_fault_q)
    && $stable(batt_fault_q) && $stable(invalid_q))
    else $error("outputs moved without a sample");

  // every accepted sample is classified one cycle later
  a_band_strobe: assert property (@(posedge clk) disable iff (!rst_n)
    sample_valid |=> band_valid_q)
    else $error("band strobe missing after sample");

  // fault and gap flags agree with the band they came from
  a_fault_agree: assert property (@(posedge clk) disable iff (!rst_n)
    open_fault_q == (band_q == alrd_pkg::BAND_OPEN) && batt_fault_q == (band_q == alrd_pkg::BAND_BATT)
    && invalid_q == (band_q == alrd_pkg::BAND_INVALID))
    else $error("fault flags disagree with band");

endmodule : alrd_decoder

// File: testbench/alrd_switch_model.sv
/*
  Momentary two-contact ladder switch with shunt and pull-down.
  Assumes the bench picks the contact state and the supply code.
*/
`timescale 1ns/1ns
module alrd_switch_model (
  input wire logic [2:0] sw_state,
  input wire logic [13:0] supply_code,
  input wire logic [13:0] forced_code,
  output logic [13:0] request_voltage,
  output logic [13:0] switch_supply_voltage
);
  ////////////////////////////////////////////////////////////
  // divider: supply * 1000 / (1000 + upper ohms)
  always_comb begin
    switch_supply_voltage = supply_code;
    case (sw_state)
      3'h0: request_voltage = 14'((32'(supply_code) * 32'h3E8) / 32'h276A); // shunt only
      3'h1: request_voltage = 14'((32'(supply_code) * 32'h3E8) / 32'hD11); // front contact
      3'h2: request_voltage = 14'((32'(supply_code) * 32'h3E8) / 32'h472); // rear contact
      3'h3: request_voltage = 14'h0; // open line, pull-down wins
      3'h4: request_voltage = supply_code; // shorted to battery
      default: request_voltage = forced_code;
    endcase
  end
endmodule : alrd_switch_model

// File: testbench/alrd_decoder_bench.sv
/*
  Self-checking bench for the decoder, fed through the ladder switch model.
  Assumes the design package is compiled first.
*/
`timescale 1ns/1ns
module alrd_decoder_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sample_valid = 1'b0;
  logic [2:0] sw_state = 3'h0;
  logic [13:0] supply_code = 14'h0;
  logic [13:0] forced_code = 14'h0;
  logic [13:0] request_voltage;
  logic [13:0] switch_supply_voltage;
  alrd_pkg::alrd_band_t band_q;
  alrd_pkg::alrd_req_t held_req_q;
  alrd_pkg::alrd_req_t exp_req = alrd_pkg::REQ_NONE;
  logic band_valid_q, front_lock_req_q, rear_lock_req_q, open_fault_q, batt_fault_q, invalid_q;
  int fail_count = 0;
  int checked = 0;

  alrd_switch_model u_switch (.sw_state(sw_state), .supply_code(supply_code), .forced_code(forced_code),
    .request_voltage(request_voltage), .switch_supply_voltage(switch_supply_voltage));
  alrd_decoder #(.ADC_W(14)) u_dut (.clk(clk), .rst_n(rst_n), .sample_valid(sample_valid),
    .request_voltage(request_voltage), .switch_supply_voltage(switch_supply_voltage), .band_q(band_q),
    .band_valid_q(band_valid_q), .held_req_q(held_req_q), .front_lock_req_q(front_lock_req_q),
    .rear_lock_req_q(rear_lock_req_q), .open_fault_q(open_fault_q), .batt_fault_q(batt_fault_q),
    .invalid_q(invalid_q));

  ////////////////////////////////////////////////////////////
  // clock and watchdog
  initial begin
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (2000) @(posedge clk);
    fail_count++;
    end_of_test();
  end

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  // one accepted sample, then band, held request and flags
  task automatic do_s(input logic [2:0] m, input logic [13:0] r, input logic [13:0] s,
    input alrd_pkg::alrd_band_t eb);
    @(posedge clk);
    #1;
    cmp(8'(band_valid_q), 8'h0);
    sw_state = m;
    forced_code = r;
    supply_code = s;
    sample_valid = 1'b1;
    @(posedge clk);
    #1;
    sample_valid = 1'b0;
    if (eb == alrd_pkg::BAND_FRONT) exp_req = alrd_pkg::REQ_FRONT;
    if (eb == alrd_pkg::BAND_REAR) exp_req = alrd_pkg::REQ_REAR;
    cmp(8'(band_q), 8'(eb));
    cmp(8'(held_req_q), 8'(exp_req));
    cmp({2'h0, band_valid_q, open_fault_q, batt_fault_q, invalid_q, front_lock_req_q, rear_lock_req_q},
      {2'h0, 1'b1, eb == alrd_pkg::BAND_OPEN, eb == alrd_pkg::BAND_BATT, eb == alrd_pkg::BAND_INVALID,
      exp_req == alrd_pkg::REQ_FRONT, exp_req == alrd_pkg::REQ_REAR});
  endtask : do_s

  task automatic t_reset;
    cmp(8'(band_q), 8'(alrd_pkg::BAND_REST));
    cmp(8'(held_req_q), 8'(alrd_pkg::REQ_NONE));
    cmp({2'h0, band_valid_q, open_fault_q, batt_fault_q, invalid_q, front_lock_req_q, rear_lock_req_q}, 8'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_ladder;
    do_s(3'h0, 14'h0, 14'hFA0, alrd_pkg::BAND_REST);
    do_s(3'h1, 14'h0, 14'hFA0, alrd_pkg::BAND_FRONT);
    do_s(3'h0, 14'h0, 14'hFA0, alrd_pkg::BAND_REST);
    do_s(3'h2, 14'h0, 14'hFA0, alrd_pkg::BAND_REAR);
    do_s(3'h3, 14'h0, 14'hFA0, alrd_pkg::BAND_OPEN);
    do_s(3'h4, 14'h0, 14'hFA0, alrd_pkg::BAND_BATT);
    $display("test ladder done");
  endtask : t_ladder

  // each band edge and its neighbour, one edge and its neighbour at half supply, then a dead supply
  task automatic t_edges;
    logic [13:0] rq [0:17] = '{14'h12C, 14'h12D, 14'h39B, 14'h39C, 14'h426, 14'h427, 14'hB01, 14'hB02,
      14'hC5E, 14'hC5F, 14'h2146, 14'h2147, 14'h231D, 14'h231E, 14'h25E3, 14'h25E4, 14'h580, 14'h581};
    logic [2:0] bd [0:17] = '{3'h0, 3'h1, 3'h1, 3'h2, 3'h2, 3'h1, 3'h1, 3'h3, 3'h3, 3'h1, 3'h1, 3'h4,
      3'h4, 3'h1, 3'h1, 3'h5, 3'h1, 3'h3};
    for (int i = 0; i < 18; i++) begin
      do_s(3'h5, rq[i], (i < 16) ? 14'h2710 : 14'h1388, alrd_pkg::alrd_band_t'(bd[i]));
    end
    do_s(3'h5, 14'h0, 14'h0, alrd_pkg::BAND_OPEN);
    do_s(3'h5, 14'h1, 14'h0, alrd_pkg::BAND_BATT);
    $display("test edges done");
  endtask : t_edges

  // back-to-back samples, then a contact change with no strobe
  task automatic t_burst;
    @(posedge clk);
    #1;
    sw_state = 3'h2;
    supply_code = 14'hFA0;
    sample_valid = 1'b1;
    @(posedge clk);
    #1;
    sw_state = 3'h3;
    exp_req = alrd_pkg::REQ_REAR;
    cmp(8'(band_q), 8'(alrd_pkg::BAND_REAR));
    cmp(8'(held_req_q), 8'(exp_req));
    @(posedge clk);
    #1;
    sample_valid = 1'b0;
    sw_state = 3'h1;
    cmp(8'(band_q), 8'(alrd_pkg::BAND_OPEN));
    cmp({2'h0, band_valid_q, open_fault_q, batt_fault_q, invalid_q, front_lock_req_q, rear_lock_req_q}, 8'h31);
    @(posedge clk);
    #1;
    cmp(8'(band_q), 8'(alrd_pkg::BAND_OPEN));
    cmp(8'(held_req_q), 8'(exp_req));
    $display("test burst done");
  endtask : t_burst

  // reset in mid-run drops a held request, rest then keeps none
  task automatic t_reset_mid;
    do_s(3'h1, 14'h0, 14'hFA0, alrd_pkg::BAND_FRONT);
    @(posedge clk);
    #1;
    rst_n = 1'b0;
    exp_req = alrd_pkg::REQ_NONE;
    @(posedge clk);
    #1;
    cmp(8'(band_q), 8'(alrd_pkg::BAND_REST));
    cmp(8'(held_req_q), 8'(exp_req));
    cmp({2'h0, band_valid_q, open_fault_q, batt_fault_q, invalid_q, front_lock_req_q, rear_lock_req_q}, 8'h0);
    rst_n = 1'b1;
    do_s(3'h0, 14'h0, 14'hFA0, alrd_pkg::BAND_REST);
    $display("test mid-run reset done");
  endtask : t_reset_mid

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_ladder();
    t_burst();
    t_edges();
    t_reset_mid();
    end_of_test();
  end
endmodule : alrd_decoder_bench
